/* chfs_regs.vh */
`ifndef CHFS_REGS_VH
`define CHFS_REGS_VH

`define CHFS_ADDR_W 16
`define CHFS_DATA_W 8

`define CHFS_LINK_FLT_OFS 16'h0532
`define CHFS_OTP_FLT_OFS 16'h0535
`define CHFS_CTRL_OFS 16'h0540
`define CHFS_FLT_CLR_OFS 16'h0541
`define CHFS_OTP_CLR_OFS 16'h0542
`define CHFS_SUMMARY_OFS 16'h0543
`define CHFS_IRQ_STAT_OFS 16'h0544
`define CHFS_IRQ_EN_OFS 16'h0545
`define CHFS_IRQ_CLR_OFS 16'h0546

`define CHFS_LINK_FLT_RST 8'h00
`define CHFS_OTP_FLT_RST 8'h00
`define CHFS_CTRL_RST 8'h00
`define CHFS_IRQ_EN_RST 8'h00

`define CHFS_BIT_HEARTBEAT_TOO_FAST_FLAG 0
`define CHFS_BIT_HB_MISS 1
`define CHFS_BIT_TONE 2
`define CHFS_BIT_RELAY 3
`define CHFS_LINK_FLT_W 4
`define CHFS_OTP_FLT_W 7

`define CHFS_BIT_DIR_SEL 0
`define CHFS_BIT_MSK_HB 1
`define CHFS_BIT_MSK_TONE 2
`define CHFS_BIT_MSK_RELAY 3
`define CHFS_BIT_HB_EN 4
`define CHFS_CTRL_W 5

`define CHFS_IRQ_OTP 4
`define CHFS_IRQ_SUMMARY 5
`define CHFS_IRQ_W 6

`define CHFS_CLK_KHZ 25000
`define CHFS_HB_MISS_US 200
`define CHFS_HEARTBEAT_TOO_FAST_FLAG_US 100
`define CHFS_TONE_FAST_US 20
`define CHFS_HB_MISS_CYC ((`CHFS_HB_MISS_US * `CHFS_CLK_KHZ) / 1000)
`define CHFS_HEARTBEAT_TOO_FAST_FLAG_CYC ((`CHFS_HEARTBEAT_TOO_FAST_FLAG_US * `CHFS_CLK_KHZ + 999) / 1000)
`define CHFS_TONE_FAST_CYC ((`CHFS_TONE_FAST_US * `CHFS_CLK_KHZ + 999) / 1000)

`endif

/* chfs_sticky_bank.v */
`timescale 1ns/1ns
module chfs_sticky_bank #(
  parameter W = 4,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire mclk,
  input wire rst_b,
  input wire [W-1:0] setIn,
  input wire [W-1:0] clrIn,
  output wire [W-1:0] flags
);

  reg [W-1:0] bits;
  genvar i;

  generate
    for (i = 0; i < W; i = i + 1) begin : gBit
      // set beats a clear in the same cycle
      always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          bits[i] <= RST_VAL[i];
        end else if (setIn[i]) begin
          bits[i] <= 1'b1;
        end else if (clrIn[i]) begin
          bits[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign flags = bits;

endmodule

/* chfs_hb_watch.v */
`timescale 1ns/1ns
module chfs_hb_watch #(
  parameter CNT_W = 16,
  parameter [CNT_W-1:0] MISS_CYC = 16'd5000,
  parameter [CNT_W-1:0] FAST_CYC = 16'd2500,
  parameter [CNT_W-1:0] TONE_CYC = 16'd500
) (
  input wire mclk,
  input wire rst_b,
  input wire enable,
  input wire dirSel,
  input wire lowerBeat,
  input wire upperBeat,
  input wire toneSeen,
  output reg missPulse,
  output reg fastPulse
);

  reg [CNT_W-1:0] gapCnt;
  reg seenBeat;
  reg expired;
  reg dirSelQ;
  wire beat;
  wire restart;
  wire early;
  wire toneEarly;

  // [RULE2] port chosen by direction
  assign beat = dirSel ? upperBeat : lowerBeat;
  // switching ports drops the old timing so no false miss
  assign restart = !enable || (dirSel != dirSelQ);
  // [RULE3] beat inside fast window
  assign early = beat && seenBeat && (gapCnt < FAST_CYC);
  // [RULE4] tone soon after beat
  assign toneEarly = toneSeen && seenBeat && (gapCnt < TONE_CYC);

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gapCnt <= {CNT_W{1'b0}};
      seenBeat <= 1'b0;
      expired <= 1'b0;
      dirSelQ <= 1'b0;
      missPulse <= 1'b0;
      fastPulse <= 1'b0;
    end else begin
      dirSelQ <= dirSel;
      missPulse <= 1'b0;
      fastPulse <= 1'b0;
      if (restart) begin
        gapCnt <= {CNT_W{1'b0}};
        seenBeat <= 1'b0;
        expired <= 1'b0;
      end else if (beat) begin
        gapCnt <= {CNT_W{1'b0}};
        seenBeat <= 1'b1;
        expired <= 1'b0;
        fastPulse <= early;
      end else begin
        fastPulse <= toneEarly;
        if (gapCnt != MISS_CYC) begin
          gapCnt <= gapCnt + 1'b1;
        end
        // [RULE1] one miss per silent gap
        if ((gapCnt == MISS_CYC) && !expired) begin
          missPulse <= 1'b1;
          expired <= 1'b1;
        end
      end
    end
  end

endmodule

/* chfs_fault_status.v */
// Summary of operation
// [RULE1] flag a missing heartbeat when none arrives within the expected time
// [RULE2] watch the lower link port when direction select is 0, else upper
// [RULE3] flag heartbeats arriving more often than the expected interval
// [RULE4] a fault tone soon after a heartbeat may also flag too fast
// [RULE5] summary fault from unmasked heartbeat flags or unmasked tone flag
// [RULE6] summary fault from unmasked relayed fault flag
// [RULE7] set tone and relayed flags on receipt; all flags reset to zero
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`include "chfs_regs.vh"
module chfs_fault_status #(
  parameter CNT_W = 16,
  parameter HB_MISS_CYC = `CHFS_HB_MISS_CYC,
  parameter HEARTBEAT_TOO_FAST_FLAG_CYC = `CHFS_HEARTBEAT_TOO_FAST_FLAG_CYC,
  parameter TONE_FAST_CYC = `CHFS_TONE_FAST_CYC
) (
  input wire mclk,
  input wire rst_b,
  input wire [`CHFS_ADDR_W-1:0] regAddr,
  input wire [`CHFS_DATA_W-1:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  output reg [`CHFS_DATA_W-1:0] regRdData,
  input wire lowerLinkBeat,
  input wire upperLinkBeat,
  input wire faultToneRx,
  input wire relayedFaultRx,
  input wire [`CHFS_OTP_FLT_W-1:0] otpFaultSet,
  output reg summaryLinkFault,
  output wire irq
);

  localparam DW = `CHFS_DATA_W;
  localparam LW = `CHFS_LINK_FLT_W;
  localparam OW = `CHFS_OTP_FLT_W;
  localparam CW = `CHFS_CTRL_W;
  localparam IW = `CHFS_IRQ_W;
  localparam [CNT_W-1:0] MISS_C = HB_MISS_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] FAST_C = HEARTBEAT_TOO_FAST_FLAG_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] TONE_C = TONE_FAST_CYC[CNT_W-1:0];
  localparam [DW-1:0] LINK_RST = `CHFS_LINK_FLT_RST;
  localparam [DW-1:0] OTP_RST = `CHFS_OTP_FLT_RST;
  localparam [DW-1:0] CTRL_RST = `CHFS_CTRL_RST;
  localparam [DW-1:0] IRQ_EN_RST = `CHFS_IRQ_EN_RST;

  reg [CW-1:0] ctrl;
  reg [IW-1:0] irqEn;
  reg summaryQ;
  reg [DW-1:0] next_rdData;

  wire wrCtrl;
  wire wrFltClr;
  wire wrOtpClr;
  wire wrIrqEn;
  wire wrIrqClr;

  wire dirSel;
  wire mskHb;
  wire mskTone;
  wire mskRelay;
  wire hbEnable;

  wire hbMissPulse;
  wire hbFastPulse;

  wire [LW-1:0] linkSet;
  wire [LW-1:0] linkClr;
  wire [LW-1:0] linkFlags;
  wire [OW-1:0] otpClr;
  wire [OW-1:0] otpFlags;
  wire [IW-1:0] irqSet;
  wire [IW-1:0] irqClr;
  wire [IW-1:0] irqStat;

  wire hbAny;
  wire next_summary;

  // write decode, single cycle strobes
  assign wrCtrl = regWrStb && (regAddr == `CHFS_CTRL_OFS);
  assign wrFltClr = regWrStb && (regAddr == `CHFS_FLT_CLR_OFS);
  assign wrOtpClr = regWrStb && (regAddr == `CHFS_OTP_CLR_OFS);
  assign wrIrqEn = regWrStb && (regAddr == `CHFS_IRQ_EN_OFS);
  assign wrIrqClr = regWrStb && (regAddr == `CHFS_IRQ_CLR_OFS);

  assign dirSel = ctrl[`CHFS_BIT_DIR_SEL];
  assign mskHb = ctrl[`CHFS_BIT_MSK_HB];
  assign mskTone = ctrl[`CHFS_BIT_MSK_TONE];
  assign mskRelay = ctrl[`CHFS_BIT_MSK_RELAY];
  assign hbEnable = ctrl[`CHFS_BIT_HB_EN];

  // control register, steers watchdog and summary
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= CTRL_RST[CW-1:0];
    end else if (wrCtrl) begin
      ctrl <= regWrData[CW-1:0];
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irqEn <= IRQ_EN_RST[IW-1:0];
    end else if (wrIrqEn) begin
      irqEn <= regWrData[IW-1:0];
    end
  end

  // [RULE2] direction select feeds watchdog
  chfs_hb_watch #(
    .CNT_W(CNT_W),
    .MISS_CYC(MISS_C),
    .FAST_CYC(FAST_C),
    .TONE_CYC(TONE_C)
  ) uWatch (
    .mclk(mclk),
    .rst_b(rst_b),
    .enable(hbEnable),
    .dirSel(dirSel),
    .lowerBeat(lowerLinkBeat),
    .upperBeat(upperLinkBeat),
    .toneSeen(faultToneRx),
    .missPulse(hbMissPulse),
    .fastPulse(hbFastPulse)
  );

  // [RULE1] missing heartbeat sets flag
  assign linkSet[`CHFS_BIT_HB_MISS] = hbMissPulse;
  // [RULE3] too fast sets flag
  assign linkSet[`CHFS_BIT_HEARTBEAT_TOO_FAST_FLAG] = hbFastPulse;
  // [RULE7] tone and relayed fault set
  assign linkSet[`CHFS_BIT_TONE] = faultToneRx;
  assign linkSet[`CHFS_BIT_RELAY] = relayedFaultRx;

  // flags are read only; software clears by write-one
  assign linkClr = wrFltClr ? regWrData[LW-1:0] : {LW{1'b0}};
  assign otpClr = wrOtpClr ? regWrData[OW-1:0] : {OW{1'b0}};

  // [RULE7] sticky flags reset to zero
  chfs_sticky_bank #(
    .W(LW),
    .RST_VAL(LINK_RST[LW-1:0])
  ) uLinkFlags (
    .mclk(mclk),
    .rst_b(rst_b),
    .setIn(linkSet),
    .clrIn(linkClr),
    .flags(linkFlags)
  );

  chfs_sticky_bank #(
    .W(OW),
    .RST_VAL(OTP_RST[OW-1:0])
  ) uOtpFlags (
    .mclk(mclk),
    .rst_b(rst_b),
    .setIn(otpFaultSet),
    .clrIn(otpClr),
    .flags(otpFlags)
  );

  assign hbAny = linkFlags[`CHFS_BIT_HB_MISS] || linkFlags[`CHFS_BIT_HEARTBEAT_TOO_FAST_FLAG];

  // [RULE5] heartbeat and tone terms
  // [RULE6] relayed fault term
  assign next_summary = (!mskHb && hbAny)
    || (!mskTone && linkFlags[`CHFS_BIT_TONE])
    || (!mskRelay && linkFlags[`CHFS_BIT_RELAY]);

  // registered so the pin never glitches on mask writes
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      summaryLinkFault <= 1'b0;
      summaryQ <= 1'b0;
    end else begin
      summaryLinkFault <= next_summary;
      summaryQ <= summaryLinkFault;
    end
  end

  // interrupt events: flag sets, otp sets, summary rising
  assign irqSet[LW-1:0] = linkSet;
  assign irqSet[`CHFS_IRQ_OTP] = |otpFaultSet;
  assign irqSet[`CHFS_IRQ_SUMMARY] = summaryLinkFault && !summaryQ;
  assign irqClr = wrIrqClr ? regWrData[IW-1:0] : {IW{1'b0}};

  chfs_sticky_bank #(
    .W(IW)
  ) uIrqStat (
    .mclk(mclk),
    .rst_b(rst_b),
    .setIn(irqSet),
    .clrIn(irqClr),
    .flags(irqStat)
  );

  assign irq = |(irqStat & irqEn);

  // read mux; unmapped and write-only addresses read zero
  always @* begin
    next_rdData = {DW{1'b0}};
    if (regRdStb) begin
      case (regAddr)
        `CHFS_LINK_FLT_OFS: begin
          next_rdData[LW-1:0] = linkFlags;
        end
        `CHFS_OTP_FLT_OFS: begin
          next_rdData[OW-1:0] = otpFlags;
        end
        `CHFS_CTRL_OFS: begin
          next_rdData[CW-1:0] = ctrl;
        end
        `CHFS_SUMMARY_OFS: begin
          next_rdData[0] = summaryLinkFault;
        end
        `CHFS_IRQ_STAT_OFS: begin
          next_rdData[IW-1:0] = irqStat;
        end
        `CHFS_IRQ_EN_OFS: begin
          next_rdData[IW-1:0] = irqEn;
        end
        default: begin
          next_rdData = {DW{1'b0}};
        end
      endcase
    end
  end

  // data valid only in the cycle after the strobe
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= {DW{1'b0}};
    end else begin
      regRdData <= next_rdData;
    end
  end

endmodule

/* chfs_fault_chk.sv */
`timescale 1ns/1ns
module chfs_fault_chk #(
  parameter MISS = 40
) (
  input wire mclk,
  input wire rst_b,
  input wire [15:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrStb,
  input wire lowerLinkBeat,
  input wire upperLinkBeat,
  input wire faultToneRx,
  input wire relayedFaultRx,
  input wire summaryLinkFault,
  input wire irq
);
  reg [7:0] ctrl;
  reg [7:0] irqEn;
  reg [15:0] gap;
  wire ctrlWr = regWrStb && regAddr == 16'h0540;
  wire sel = ctrl[0] ? upperLinkBeat : lowerLinkBeat;
  // gap saturates so a long quiet run cannot wrap back onto the limit
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= 8'h00;
      irqEn <= 8'h00;
      gap <= 16'h0000;
    end else begin
      if (ctrlWr) begin
        ctrl <= regWrData;
      end
      if (regWrStb && regAddr == 16'h0545) begin
        irqEn <= regWrData;
      end
      if (!ctrl[4] || sel || ctrlWr) begin
        gap <= 16'h0000;
      end else if (gap != 16'hFFFF) begin
        gap <= gap + 16'h0001;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_beat_too_fast:
    assert property (ctrl[4] && !ctrl[1] && sel ##10 sel |-> ##[1:4] summaryLinkFault)
    else $error("fast beats not reported");
  a_beat_missing:
    assert property (gap == MISS + 6 && !ctrl[1] |-> summaryLinkFault)
    else $error("missing beat not reported");
  a_tone_after_beat:
    assert property (ctrl[4] && !ctrl[1] && sel ##1 faultToneRx |-> ##[1:4] summaryLinkFault)
    else $error("early tone not reported");
  a_tone_summary:
    assert property (faultToneRx && !ctrl[2] |-> ##[1:3] summaryLinkFault)
    else $error("tone not reported");
  a_relay_summary:
    assert property (relayedFaultRx && !ctrl[3] |-> ##[1:3] summaryLinkFault)
    else $error("relayed fault not reported");
  a_masked_quiet:
    assert property ($past(&ctrl[3:1]) |-> !summaryLinkFault)
    else $error("summary raised while masked");
  a_irq_off:
    assert property (irqEn == 8'h00 |-> !irq)
    else $error("irq raised while disabled");
  c_fast: cover property (sel ##10 sel);
  c_tone: cover property (faultToneRx && !ctrl[2]);
  c_irq: cover property ($rose(irq));
endmodule

bind chfs_fault_status chfs_fault_chk #(.MISS(HB_MISS_CYC)) u_chk (
  .mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
  .regWrStb(regWrStb), .lowerLinkBeat(lowerLinkBeat), .upperLinkBeat(upperLinkBeat),
  .faultToneRx(faultToneRx), .relayedFaultRx(relayedFaultRx),
  .summaryLinkFault(summaryLinkFault), .irq(irq)
);

/* chfs_chain_peer.sv */
`timescale 1ns/1ns
module chfs_chain_peer (
  input wire mclk,
  input wire rst_b,
  input wire run,
  input wire [15:0] beatGap,
  input wire useUpper,
  input wire [15:0] toneDly,
  input wire relayReq,
  output reg lowerLinkBeat,
  output reg upperLinkBeat,
  output reg faultToneRx,
  output reg relayedFaultRx
);
  reg [15:0] cnt;
  wire due = run && cnt == beatGap - 16'h0001;
  // beats and tone stay quiet when not running, which is what the watchdog must catch
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 16'h0000;
      lowerLinkBeat <= 1'b0;
      upperLinkBeat <= 1'b0;
      faultToneRx <= 1'b0;
      relayedFaultRx <= 1'b0;
    end else begin
      cnt <= (due || !run) ? 16'h0000 : cnt + 16'h0001;
      lowerLinkBeat <= due && !useUpper;
      upperLinkBeat <= due && useUpper;
      faultToneRx <= run && toneDly != 16'h0000 && cnt == toneDly - 16'h0001;
      relayedFaultRx <= relayReq;
    end
  end
endmodule

/* chfs_tb.sv */
`timescale 1ns/1ns
module tb;
  reg mclk = 1'b0, rst_b = 1'b0, regWrStb = 1'b0, regRdStb = 1'b0;
  reg run = 1'b0, useUpper = 1'b0, relayReq = 1'b0, es;
  reg [15:0] regAddr = 16'h0000, beatGap = 16'h000A, toneDly = 16'h0000;
  reg [7:0] regWrData = 8'h00, c, g, u, t, ef;
  reg [6:0] otpFaultSet = 7'h00;
  reg [39:0] rows [0:9];
  reg [127:0] ra = 128'h05320535054005430544054505410600;
  wire [7:0] regRdData;
  wire lowerLinkBeat, upperLinkBeat, faultToneRx, relayedFaultRx, summaryLinkFault, irq;
  integer failures = 0, comparisons = 0, i;
  always #20 mclk = ~mclk;
  chfs_fault_status #(.HB_MISS_CYC(40), .HEARTBEAT_TOO_FAST_FLAG_CYC(20), .TONE_FAST_CYC(5)) u_dut (
    .mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .lowerLinkBeat(lowerLinkBeat), .upperLinkBeat(upperLinkBeat),
    .faultToneRx(faultToneRx), .relayedFaultRx(relayedFaultRx),
    .otpFaultSet(otpFaultSet), .summaryLinkFault(summaryLinkFault), .irq(irq)
  );
  chfs_chain_peer u_peer (
    .mclk(mclk), .rst_b(rst_b), .run(run), .beatGap(beatGap), .useUpper(useUpper),
    .toneDly(toneDly), .relayReq(relayReq), .lowerLinkBeat(lowerLinkBeat),
    .upperLinkBeat(upperLinkBeat), .faultToneRx(faultToneRx), .relayedFaultRx(relayedFaultRx)
  );
  task check(input [7:0] seen, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge mclk);
      regWrStb <= 1'b0;
    end
  endtask
  task rdc(input [15:0] a, input [7:0] e);
    begin
      @(posedge mclk);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge mclk);
      regRdStb <= 1'b0;
      @(negedge mclk);
      check(regRdData, e);
    end
  endtask
  task relay;
    begin
      @(posedge mclk);
      relayReq <= 1'b1;
      @(posedge mclk);
      relayReq <= 1'b0;
      cyc(5);
    end
  endtask
  task final_report;
    begin
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    cyc(3000);
    failures = failures + 1;
    final_report;
  end
  initial begin
    // ctrl, beat gap, upper port, tone delay, expected flags
    rows[0] = 40'h100A000001;
    rows[1] = 40'h110A010001;
    rows[2] = 40'h110A000002;
    rows[3] = 40'h101E000000;
    rows[4] = 40'h000A000000;
    rows[5] = 40'h141E000105;
    rows[6] = 40'h141E000A04;
    rows[7] = 40'h100A010002;
    rows[8] = 40'h001E000A04;
    rows[9] = 40'h1E0A000105;
    cyc(20);
    rst_b <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      rdc(ra[16*i +: 16], 8'h00);
    end
    for (i = 0; i < 10; i = i + 1) begin
      {c, g, u, t, ef} = rows[i];
      wr(16'h0540, 8'h00);
      wr(16'h0541, 8'h0F);
      wr(16'h0540, c);
      beatGap <= {8'h00, g};
      useUpper <= u[0];
      toneDly <= {8'h00, t};
      run <= 1'b1;
      cyc(80);
      run <= 1'b0;
      rdc(16'h0532, ef);
      es = (|ef[1:0] && !c[1]) || (ef[2] && !c[2]);
      check({7'h00, summaryLinkFault}, {7'h00, es});
    end
    wr(16'h0540, 8'h00);
    wr(16'h0541, 8'h0F);
    wr(16'h0546, 8'hFF);
    wr(16'h0545, 8'h08);
    @(negedge mclk);
    check({7'h00, irq}, 8'h00);
    relay;
    rdc(16'h0532, 8'h08);
    rdc(16'h0543, 8'h01);
    check({7'h00, irq}, 8'h01);
    // relay event and summary rise both latched
    rdc(16'h0544, 8'h28);
    wr(16'h0545, 8'h00);
    @(negedge mclk);
    check({7'h00, irq}, 8'h00);
    wr(16'h0545, 8'h08);
    wr(16'h0546, 8'h08);
    @(negedge mclk);
    check({7'h00, irq}, 8'h00);
    wr(16'h0540, 8'h08);
    wr(16'h0541, 8'h0F);
    relay;
    check({7'h00, summaryLinkFault}, 8'h00);
    // read-only place must ignore the write
    wr(16'h0532, 8'hFF);
    rdc(16'h0532, 8'h08);
    @(posedge mclk);
    otpFaultSet <= 7'h41;
    @(posedge mclk);
    otpFaultSet <= 7'h00;
    rdc(16'h0535, 8'h41);
    wr(16'h0542, 8'h7F);
    rdc(16'h0535, 8'h00);
    // reset after the last run, with the peer stopped, drops every flag
    @(posedge mclk);
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    rdc(16'h0532, 8'h00);
    rdc(16'h0540, 8'h00);
    final_report;
  end
endmodule
